/* rtl/low_power_mode_controller.sv */
`timescale 1ns/1ps
`include "lpm_params.svh"

// Functional notes
// - Sleep stops CPU clock, peripherals keep running
// - Masked or disabled interrupt keeps sleep
// - Sleep exit goes active or subactive by low_speed_select
// - Reset pin low ends sleep, resets CPU
// - Standby halts oscillator, CPU, peripherals; ports tristate
// - Standby wake restarts oscillator, waits selected period
// - Masked or disabled interrupt keeps standby
// - Reset in standby starts oscillator, supplies clock
// - Pin release after stabilisation ends internal reset
// - Subsleep halts all but real-time clock
// - Masked or disabled interrupt keeps subsleep
// - Subsleep exit goes active or subactive
// - Subsleep to active waits stabilisation time
// - Subactive clock is watch clock /2 /4 /8
// - Subclock divider applies only at SLEEP
// - SLEEP in subactive decodes both control registers
// - Active divider applies only at SLEEP
// - Direct transition switches modes, raises direct exception
// - Direct interrupt disabled gives sleep or subsleep
// - Direct transition under mask locks sleep or subsleep until reset
// - Active to subactive timing old then new clock
// - Subactive to active adds stabilisation wait
// - Per-module standby bit gates module clock
// - SLEEP target decode of control bits
module low_power_mode_controller
	import lpm_pkg::*;
#(
	parameter int NUM_IRQ = 8,
	parameter int NUM_MOD = 8,
	parameter int unsigned WAIT_CNT [8] = '{`WAIT_CNT_0, `WAIT_CNT_1, `WAIT_CNT_2,
		`WAIT_CNT_3, `WAIT_CNT_4, `WAIT_CNT_5, `WAIT_CNT_6, `WAIT_CNT_7},
	parameter int unsigned POR_WAIT = `POR_WAIT_CNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_pin_n,
	input wire logic sleep_exec,
	input wire logic ccr_int_mask,
	input wire logic [NUM_IRQ-1:0] irq_pending,
	input wire logic [NUM_IRQ-1:0] irq_enable,
	input wire logic dt_irq_enable,
	input wire logic watch_tick,
	output clk_en_s clk_en,
	output logic [NUM_MOD-1:0] module_clk_en,
	output logic osc_run,
	output logic io_hiz,
	output logic internal_reset_n,
	output logic exc_start,
	output logic dt_exc_start,
	output pmode_e mode
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int CW = 32;

	logic [7:0] sc1_q; // system_control_one
	logic [7:0] sc2_q; // system_control_two
	logic [NUM_MOD-1:0] mstby_q; // Per-module standby bits
	clk_setting_s applied_q; // Divider settings in force
	pmode_e state_q; // Current operating mode
	pmode_e wait_target_q; // Mode to take after the wait
	logic wait_dt_q; // Wait ends in a direct exception
	logic [CW-1:0] wait_cnt_q; // Stabilisation down-counter
	logic [CW-1:0] por_cnt_q; // Counts while reset pin is low
	logic por_done_q; // Oscillator stable under reset
	logic int_reset_n_q; // Internal reset, low active
	logic lock_q; // Halt that no interrupt ends
	logic [1:0] dt_cnt_q; // Internal processing states left
	logic dt_to_sub_q; // Direct transition goes to subactive
	logic [6:0] adiv_cnt_q; // Active-mode divider
	logic [2:0] sdiv_cnt_q; // Subclock divider
	logic exc_q; // Exception start pulse
	logic dt_exc_q; // Direct exception start pulse
	logic wake; // Enabled unmasked interrupt
	logic act_tick; // Active-mode rate enable
	logic sub_tick; // Subactive rate enable
	logic apb_wr; // Write strobe
	logic sleep_go; // SLEEP taken in a running mode
	logic dt_go, dt_done; // Direct move chosen, direct move ends

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Last divider count, one less than the watch-clock ticks per subactive CPU state
	function automatic logic [2:0] sub_div_last(input logic [1:0] sel);
		case (sel)
			2'h0: sub_div_last = 3'h7; // /8
			2'h1: sub_div_last = 3'h3; // /4
			default: sub_div_last = 3'h1; // /2
		endcase
	endfunction : sub_div_last

	// Halt mode chosen by subsleep_select
	function automatic pmode_e halt_mode(input logic subsleep);
		halt_mode = subsleep ? ST_SUBSLEEP : ST_SLEEP;
	endfunction : halt_mode

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite;

	// Unmapped addresses answer with an error
	always_comb begin
		pslverr = 1'b0;
		prdata = 32'h0000_0000;
		case (paddr)
			`OFS_SYS_CTRL_ONE: prdata = {24'h00_0000, sc1_q};
			`OFS_SYS_CTRL_TWO: prdata = {24'h00_0000, sc2_q};
			`OFS_MODULE_STBY: prdata = 32'(mstby_q);
			`OFS_STATUS: prdata = {22'h00_0000, lock_q, int_reset_n_q,
				applied_q, state_q};
			default: pslverr = psel && penable;
		endcase
	end

	// Control register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc1_q <= `SC1_RESET;
			sc2_q <= `SC2_RESET;
			mstby_q <= '0;
		end else if (!int_reset_n_q) begin
			sc1_q <= `SC1_RESET;
			sc2_q <= `SC2_RESET;
			mstby_q <= '0;
		end else if (apb_wr) begin
			case (paddr)
				`OFS_SYS_CTRL_ONE: sc1_q <= pwdata[7:0];
				`OFS_SYS_CTRL_TWO: sc2_q <= pwdata[7:0];
				`OFS_MODULE_STBY: mstby_q <= pwdata[NUM_MOD-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Reset pin and power-on wait
	// ****************************************************************
	// Counts how long the pin has been low, so release waits for a stable clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_cnt_q <= '0;
			por_done_q <= 1'b0;
			int_reset_n_q <= 1'b0;
		end else if (!reset_pin_n) begin
			int_reset_n_q <= 1'b0;
			if (por_cnt_q >= CW'(POR_WAIT - 1)) begin
				por_done_q <= 1'b1;
			end else begin
				por_cnt_q <= por_cnt_q + 1'b1;
			end
		end else begin
			por_cnt_q <= '0;
			if (por_done_q) begin
				int_reset_n_q <= 1'b1;
			end
			por_done_q <= 1'b0;
		end
	end

	assign internal_reset_n = int_reset_n_q;

	// ****************************************************************
	// Wake and SLEEP decode
	// ****************************************************************
	assign wake = (|(irq_pending & irq_enable)) && !ccr_int_mask && !lock_q;
	assign sleep_go = sleep_exec && int_reset_n_q &&
		(state_q == ST_ACTIVE || state_q == ST_SUBACTIVE);
	assign dt_go = sc2_q[`SC2_DIRECT_BIT] && !ccr_int_mask && dt_irq_enable;
	assign dt_done = (state_q == ST_DT_PROC) && clk_en.cpu && (dt_cnt_q == 2'h0);

	// ****************************************************************
	// Mode state machine
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RESET;
			wait_target_q <= ST_ACTIVE;
			wait_dt_q <= 1'b0;
			wait_cnt_q <= '0;
			lock_q <= 1'b0;
			dt_cnt_q <= 2'h0;
			dt_to_sub_q <= 1'b0;
			exc_q <= 1'b0;
			dt_exc_q <= 1'b0;
		end else if (!int_reset_n_q) begin
			// Reset overrides every mode
			state_q <= ST_RESET;
			lock_q <= 1'b0;
			exc_q <= 1'b0;
			dt_exc_q <= 1'b0;
		end else begin
			exc_q <= 1'b0;
			dt_exc_q <= 1'b0;
			case (state_q)
				ST_RESET: begin
					state_q <= ST_ACTIVE;
				end
				ST_ACTIVE, ST_SUBACTIVE: begin
					if (sleep_go) begin
						if (sc2_q[`SC2_DIRECT_BIT]) begin
							if (ccr_int_mask) begin
								// Halt that interrupts cannot end
								state_q <= halt_mode(sc2_q[`SC2_SUBSLEEP_BIT]);
								lock_q <= 1'b1;
							end else if (!dt_irq_enable) begin
								state_q <= halt_mode(sc2_q[`SC2_SUBSLEEP_BIT]);
							end else begin
								// Internal processing at the old clock
								state_q <= ST_DT_PROC;
								dt_cnt_q <= 2'(`DT_INTERNAL_STATES);
								dt_to_sub_q <= sc2_q[`SC2_LOWSPEED_BIT];
							end
						end else if (sc1_q[`SC1_STANDBY_BIT]) begin
							state_q <= ST_STANDBY;
						end else begin
							state_q <= halt_mode(sc2_q[`SC2_SUBSLEEP_BIT]);
						end
					end
				end
				ST_DT_PROC: begin
					// Internal states counted at the rate of the old mode
					if (clk_en.cpu) begin
						if (dt_cnt_q == 2'h0) begin
							if (dt_to_sub_q) begin
								state_q <= ST_SUBACTIVE;
								dt_exc_q <= 1'b1;
							end else begin
								// Oscillator must settle first
								state_q <= ST_WAKE_WAIT;
								wait_target_q <= ST_ACTIVE;
								wait_dt_q <= 1'b1;
								wait_cnt_q <= CW'(WAIT_CNT[sc1_q[`SC1_WAIT_MSB:`SC1_WAIT_LSB]]);
							end
						end else begin
							dt_cnt_q <= dt_cnt_q - 2'h1;
						end
					end
				end
				ST_SLEEP: begin
					if (wake) begin
						state_q <= sc2_q[`SC2_LOWSPEED_BIT] ? ST_SUBACTIVE : ST_ACTIVE;
						exc_q <= 1'b1;
					end
				end
				ST_SUBSLEEP: begin
					if (wake) begin
						if (sc2_q[`SC2_LOWSPEED_BIT]) begin
							state_q <= ST_SUBACTIVE;
							exc_q <= 1'b1;
						end else begin
							state_q <= ST_WAKE_WAIT;
							wait_target_q <= ST_ACTIVE;
							wait_dt_q <= 1'b0;
							wait_cnt_q <= CW'(WAIT_CNT[sc1_q[`SC1_WAIT_MSB:`SC1_WAIT_LSB]]);
						end
					end
				end
				ST_STANDBY: begin
					if (wake) begin
						// Restart oscillator, load the settling count
						state_q <= ST_WAKE_WAIT;
						wait_target_q <= ST_ACTIVE;
						wait_dt_q <= 1'b0;
						wait_cnt_q <= CW'(WAIT_CNT[sc1_q[`SC1_WAIT_MSB:`SC1_WAIT_LSB]]);
					end
				end
				ST_WAKE_WAIT: begin
					// Down-counter on the running oscillator clock
					if (wait_cnt_q <= CW'(1)) begin
						state_q <= wait_target_q;
						exc_q <= !wait_dt_q;
						dt_exc_q <= wait_dt_q;
					end else begin
						wait_cnt_q <= wait_cnt_q - 1'b1;
					end
				end
				default: begin
					state_q <= ST_RESET;
				end
			endcase
		end
	end

	assign mode = state_q;
	assign exc_start = exc_q;
	assign dt_exc_start = dt_exc_q;

	// ****************************************************************
	// Divider settings applied at SLEEP
	// ****************************************************************
	// Field writes wait for SLEEP; a direct move keeps the old rate until it ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied_q <= '0;
		end else if (!int_reset_n_q) begin
			applied_q <= '0;
		end else if ((sleep_go && !dt_go) || dt_done) begin
			applied_q.adiv <= sc2_q[`SC2_ADIV_MSB:`SC2_ADIV_LSB];
			applied_q.sdiv <= sc2_q[`SC2_SDIV_MSB:`SC2_SDIV_LSB];
		end
	end

	// ****************************************************************
	// Clock dividers
	// ****************************************************************
	// Active rate: pclk divided by 2 to the power of the field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adiv_cnt_q <= '0;
		end else if (act_tick) begin
			adiv_cnt_q <= '0;
		end else begin
			adiv_cnt_q <= adiv_cnt_q + 7'h01;
		end
	end

	assign act_tick = (adiv_cnt_q >= 7'((8'h01 << applied_q.adiv) - 8'h01));

	// Subactive rate: watch ticks divided by 2, 4 or 8
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdiv_cnt_q <= '0;
		end else if (watch_tick) begin
			if (sdiv_cnt_q >= sub_div_last(applied_q.sdiv)) begin
				sdiv_cnt_q <= '0;
			end else begin
				sdiv_cnt_q <= sdiv_cnt_q + 3'h1;
			end
		end
	end

	assign sub_tick = watch_tick && (sdiv_cnt_q >= sub_div_last(applied_q.sdiv));

	// ****************************************************************
	// Clock gating and pin state per mode
	// ****************************************************************
	always_comb begin
		clk_en.rtc = watch_tick;
		case (state_q)
			ST_ACTIVE: begin
				clk_en.cpu = act_tick;
				clk_en.periph = act_tick;
			end
			ST_SLEEP: begin
				clk_en.cpu = 1'b0;
				clk_en.periph = act_tick;
			end
			ST_SUBACTIVE: begin
				clk_en.cpu = sub_tick;
				clk_en.periph = sub_tick;
			end
			ST_DT_PROC: begin
				clk_en.cpu = dt_to_sub_q ? act_tick : sub_tick;
				clk_en.periph = 1'b0;
			end
			ST_RESET: begin
				clk_en.cpu = 1'b0;
				clk_en.periph = por_done_q;
			end
			default: begin
				// Subsleep, standby and settling: CPU and peripheral clocks halted
				clk_en.cpu = 1'b0;
				clk_en.periph = 1'b0;
			end
		endcase
	end

	// Module clocks stop while their standby bit is set
	assign module_clk_en = {NUM_MOD{clk_en.periph}} & ~mstby_q;

	// Main oscillator halts in standby, subsleep and subactive
	assign osc_run = !(state_q == ST_STANDBY || state_q == ST_SUBSLEEP ||
		state_q == ST_SUBACTIVE);

	// Port outputs float only in standby
	assign io_hiz = (state_q == ST_STANDBY);

endmodule : low_power_mode_controller

/* shared/lpm_params.svh */
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_SYS_CTRL_ONE 12'h000
`define OFS_SYS_CTRL_TWO 12'h004
`define OFS_MODULE_STBY 12'h008
`define OFS_STATUS 12'h00C

// ****************************************************************
// Field positions of system_control_one
// ****************************************************************
`define SC1_STANDBY_BIT 7
`define SC1_WAIT_LSB 4
`define SC1_WAIT_MSB 6

// ****************************************************************
// Field positions of system_control_two
// ****************************************************************
`define SC2_SUBSLEEP_BIT 7
`define SC2_LOWSPEED_BIT 6
`define SC2_DIRECT_BIT 5
`define SC2_ADIV_LSB 2
`define SC2_ADIV_MSB 4
`define SC2_SDIV_LSB 0
`define SC2_SDIV_MSB 1

// ****************************************************************
// Reset values
// ****************************************************************
`define SC1_RESET 8'h00
`define SC2_RESET 8'h00

// ****************************************************************
// Timing counts, in pclk cycles or CPU states
// ****************************************************************
`define WAIT_CNT_0 8192
`define WAIT_CNT_1 16384
`define WAIT_CNT_2 1024
`define WAIT_CNT_3 2048
`define WAIT_CNT_4 4096
`define WAIT_CNT_5 2
`define WAIT_CNT_6 8
`define WAIT_CNT_7 16
`define POR_WAIT_CNT 8192
`define DT_INTERNAL_STATES 1

`endif

/* shared/lpm_pkg.sv */
package lpm_pkg;

	// Operating modes; Gray code sequence in declaration order
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_ACTIVE = 3'h1,
		ST_SLEEP = 3'h3,
		ST_WAKE_WAIT = 3'h2,
		ST_STANDBY = 3'h6,
		ST_SUBSLEEP = 3'h7,
		ST_SUBACTIVE = 3'h5,
		ST_DT_PROC = 3'h4
	} pmode_e;

	// Settings latched when a SLEEP instruction executes
	typedef struct packed {
		logic [2:0] adiv;
		logic [1:0] sdiv;
	} clk_setting_s;

	// Clock enables delivered to the chip
	typedef struct packed {
		logic cpu;
		logic periph;
		logic rtc;
	} clk_en_s;

endpackage : lpm_pkg

/* dv/lpm_checker_assertions.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checker of the power-mode controller
// ****************************************************************
module lpm_checker
	import lpm_pkg::*;
#(
	parameter int NUM_MOD = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_pin_n,
	input wire logic ccr_int_mask,
	input wire logic watch_tick,
	input wire clk_en_s clk_en,
	input wire logic [NUM_MOD-1:0] module_clk_en,
	input wire logic osc_run,
	input wire logic io_hiz,
	input wire logic internal_reset_n,
	input wire logic exc_start,
	input wire logic dt_exc_start,
	input wire pmode_e mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_sleep_cpu_stop: assert property (mode == ST_SLEEP |-> !clk_en.cpu)
		else $error("cpu clock runs in sleep");
	a_masked_hold: assert property (
		mode inside {ST_SLEEP, ST_SUBSLEEP, ST_STANDBY} && ccr_int_mask && reset_pin_n
		|=> $stable(mode)) else $error("masked interrupt released halt");
	a_sleep_exit: assert property ($past(mode) == ST_SLEEP &&
		!(mode inside {ST_SLEEP, ST_RESET}) |-> exc_start && mode inside {ST_ACTIVE, ST_SUBACTIVE})
		else $error("bad sleep exit");
	a_pin_reset: assert property (!reset_pin_n |=> !internal_reset_n ##1 mode == ST_RESET)
		else $error("pin low did not reset");
	a_standby_off: assert property (mode == ST_STANDBY |->
		io_hiz && !osc_run && !clk_en.cpu && !clk_en.periph) else $error("standby not halted");
	a_standby_exit: assert property ($past(mode) == ST_STANDBY &&
		!(mode inside {ST_STANDBY, ST_RESET}) |-> mode == ST_WAKE_WAIT && osc_run)
		else $error("standby left without wait");
	a_reset_osc: assert property (mode == ST_RESET |-> osc_run)
		else $error("oscillator off in reset");
	a_rst_release: assert property ($rose(internal_reset_n) |-> reset_pin_n)
		else $error("internal reset released with pin low");
	a_subsleep_rtc: assert property (mode == ST_SUBSLEEP |->
		!clk_en.cpu && !clk_en.periph && clk_en.rtc == watch_tick) else $error("subsleep clocks");
	a_dt_exc: assert property (dt_exc_start |-> mode inside {ST_ACTIVE, ST_SUBACTIVE} &&
		$past(mode) inside {ST_DT_PROC, ST_WAKE_WAIT}) else $error("direct exception misplaced");
	a_mod_gate: assert property (|module_clk_en |-> clk_en.periph)
		else $error("module clock without peripheral clock");
	// Main scenarios reached
	c_sleep_wake: cover property ($past(mode) == ST_SLEEP && mode == ST_ACTIVE);
	c_wait_done: cover property (mode == ST_WAKE_WAIT ##1 mode == ST_ACTIVE);
	c_direct: cover property (dt_exc_start);
endmodule : lpm_checker

/* dv/cpu_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// CPU core side: SLEEP pulses, watch ticks, reset pin
// ****************************************************************
module cpu_model (
	input wire logic pclk,
	output logic sleep_exec,
	output logic watch_tick,
	output logic reset_pin_n
);
	logic [1:0] div_q = 2'h0; // Watch clock prescale
	// Watch tick once every four cycles
	always_ff @(posedge pclk) begin
		div_q <= div_q + 2'h1;
	end
	assign watch_tick = (div_q == 2'h3);
	initial begin
		sleep_exec = 1'b0;
		reset_pin_n = 1'b1;
	end
	// One-cycle SLEEP pulse
	task automatic sleep_cmd();
		@(posedge pclk);
		sleep_exec <= 1'b1;
		@(posedge pclk);
		sleep_exec <= 1'b0;
	endtask : sleep_cmd
	// Pin held low for cnt cycles, then released
	task automatic pin_reset(input int cnt);
		@(posedge pclk);
		reset_pin_n <= 1'b0;
		repeat (cnt) @(posedge pclk);
		reset_pin_n <= 1'b1;
	endtask : pin_reset
endmodule : cpu_model

/* dv/low_power_mode_controller_bench.sv */
`timescale 1ns/1ps
`define CHK(s, e, g) begin checks++; if ((e) !== (g)) begin errors++; \
	$display("MISMATCH %s exp %0h got %0h", s, e, g); end end
module low_power_mode_controller_bench;
	import lpm_pkg::*;
	localparam int unsigned WT [8] = '{3, 4, 5, 6, 7, 2, 8, 9}; // Short wait table
	localparam int POR = 8;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic ccr_int_mask = 1'b0;
	logic dt_irq_enable = 1'b0;
	logic [7:0] irq_pending = 8'h00;
	logic [7:0] irq_enable = 8'h00;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, reset_pin_n, sleep_exec, watch_tick, osc_run, io_hiz;
	logic internal_reset_n, exc_start, dt_exc_start;
	logic [7:0] module_clk_en, b;
	clk_en_s clk_en;
	pmode_e mode;
	int errors = 0, checks = 0, seed = 14, n, c, i, cyc = 0;
	cpu_model cpu (.pclk(pclk), .sleep_exec(sleep_exec), .watch_tick(watch_tick),
		.reset_pin_n(reset_pin_n));
	low_power_mode_controller #(.WAIT_CNT(WT), .POR_WAIT(POR)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_pin_n(reset_pin_n), .sleep_exec(sleep_exec), .ccr_int_mask(ccr_int_mask),
		.irq_pending(irq_pending), .irq_enable(irq_enable), .dt_irq_enable(dt_irq_enable),
		.watch_tick(watch_tick), .clk_en(clk_en), .module_clk_en(module_clk_en),
		.osc_run(osc_run), .io_hiz(io_hiz), .internal_reset_n(internal_reset_n),
		.exc_start(exc_start), .dt_exc_start(dt_exc_start), .mode(mode));
	// 125 MHz clock
	initial begin
		forever #4 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	// One APB transfer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic irq(input logic [7:0] p, input logic [7:0] e, input logic m, input logic d);
		@(posedge pclk);
		irq_pending <= p;
		irq_enable <= e;
		ccr_int_mask <= m;
		dt_irq_enable <= d;
	endtask : irq
	// Wait for a mode, counting cycles
	task automatic wm(input pmode_e m);
		n = 0;
		while (mode !== m && n < 3000) begin
			@(posedge pclk);
			#1;
			n++;
		end
		`CHK("mode", m, mode)
	endtask : wm
	task automatic slp(input pmode_e m);
		cpu.sleep_cmd();
		#1;
		`CHK("target", m, mode)
	endtask : slp
	// CPU enables over len cycles
	task automatic cnt(input int len);
		c = 0;
		repeat (len) begin
			@(posedge pclk);
			#1;
			c += (clk_en.cpu === 1'b1);
		end
	endtask : cnt
	task automatic por();
		cpu.pin_reset(POR + 2);
		wm(ST_ACTIVE);
		`CHK("ireset", 1'b1, internal_reset_n)
	endtask : por
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		por();
		apb(0, 12'h00C, 0);
		`CHK("status", 32'h0000_0101, rd)
		apb(0, 12'h004, 0);
		`CHK("sc2", 32'h0, rd)
		apb(0, 12'h010, 0);
		`CHK("unmapped", 1'b1, err)
		b = 8'h01 << ($unsigned($random(seed)) % 8);
		apb(1, 12'h008, $random(seed));
		#1;
		`CHK("modclk", ~pwdata[7:0], module_clk_en)
		apb(1, 12'h008, 0);
		#1;
		`CHK("modclk", 8'hFF, module_clk_en)
		apb(1, 12'h004, 32'h0B);
		cnt(32);
		`CHK("adiv old", 32, c)
		irq(b, b, 0, 0);
		slp(ST_SLEEP);
		`CHK("cpu", 1'b0, clk_en.cpu)
		wm(ST_ACTIVE);
		`CHK("exc", 1'b1, exc_start)
		cnt(32);
		`CHK("adiv new", 8, c)
		irq(b, b, 1, 0);
		slp(ST_SLEEP);
		irq(b, ~b, 0, 0);
		repeat (16) @(posedge pclk);
		#1;
		`CHK("held", ST_SLEEP, mode)
		irq(b, b, 0, 0);
		wm(ST_ACTIVE);
		apb(1, 12'h004, 32'h4B);
		slp(ST_SLEEP);
		wm(ST_SUBACTIVE);
		apb(1, 12'h004, 32'h48);
		cnt(64);
		`CHK("sdiv", 8, c)
		$display("end sleep");
		irq(0, 0, 0, 0);
		i = $unsigned($random(seed)) % 8;
		apb(1, 12'h000, i << 4);
		apb(1, 12'h004, 32'h80);
		slp(ST_SUBSLEEP);
		irq(b, b, 1, 0);
		repeat (8) @(posedge pclk);
		#1;
		`CHK("held", ST_SUBSLEEP, mode)
		irq(b, b, 0, 0);
		wm(ST_WAKE_WAIT);
		wm(ST_ACTIVE);
		`CHK("wait", WT[i], n)
		$display("end subsleep");
		for (i = 0; i < 8; i++) begin
			irq(0, 0, 0, 0);
			apb(1, 12'h000, 32'h80 | (i << 4));
			slp(ST_STANDBY);
			`CHK("hiz", 1'b1, io_hiz)
			irq(b, b, 1, 0);
			repeat (4) @(posedge pclk);
			#1;
			`CHK("held", ST_STANDBY, mode)
			irq(b, b, 0, 0);
			wm(ST_WAKE_WAIT);
			wm(ST_ACTIVE);
			`CHK("wait", WT[i], n)
		end
		$display("end standby");
		irq(0, 0, 0, 1);
		apb(1, 12'h000, 0);
		apb(1, 12'h004, 32'h6B);
		slp(ST_DT_PROC);
		wm(ST_SUBACTIVE);
		`CHK("dtexc", 1'b1, dt_exc_start)
		`CHK("dt old", 2, n)
		apb(1, 12'h004, 32'h28);
		slp(ST_DT_PROC);
		wm(ST_ACTIVE);
		`CHK("dtexc", 1'b1, dt_exc_start)
		irq(b, b, 0, 0);
		slp(ST_SLEEP);
		wm(ST_ACTIVE);
		irq(0, 0, 1, 1);
		slp(ST_SLEEP);
		irq(b, b, 0, 1);
		repeat (16) @(posedge pclk);
		#1;
		`CHK("lock", ST_SLEEP, mode)
		$display("end direct");
		fork
			cpu.pin_reset(POR + 2);
			begin
				repeat (3) @(posedge pclk);
				#1;
				`CHK("rst", ST_RESET, mode)
			end
		join
		wm(ST_ACTIVE);
		apb(0, 12'h004, 0);
		`CHK("sc2", 32'h0, rd)
		$display("end reset");
		close_out();
	end
endmodule : low_power_mode_controller_bench
bind low_power_mode_controller lpm_checker #(.NUM_MOD(NUM_MOD)) chk (.pclk(pclk),
	.presetn(presetn), .reset_pin_n(reset_pin_n), .ccr_int_mask(ccr_int_mask),
	.watch_tick(watch_tick), .clk_en(clk_en), .module_clk_en(module_clk_en),
	.osc_run(osc_run), .io_hiz(io_hiz), .internal_reset_n(internal_reset_n),
	.exc_start(exc_start), .dt_exc_start(dt_exc_start), .mode(mode));
